// ===== core/spi_cfg_defines.svh
// constants for the serial-port configuration register bank
// assumes a 15-bit byte address and 8-bit serial data frames
`ifndef SPI_CFG_DEFINES_SVH
`define SPI_CFG_DEFINES_SVH

// register byte addresses
`define OFS_IFACE_CFG 15'h0000
`define OFS_DEV_STATE 15'h0002
`define OFS_MAKER_LO 15'h000c
`define OFS_MAKER_HI 15'h000d
`define OFS_USER_OPTS 15'h0010

// interface configuration fields
`define CFG_SOFT_RESET_BIT 7
`define CFG_ASCEND_BIT 5
`define CFG_OUT_ONLY_BIT 4
`define CFG_WRITE_MASK 8'h6f
`define CFG_FIXED_ONES 8'h10

// reset values
`define IFACE_CFG_RESET 8'h30
`define DEV_STATE_RESET 8'h00
`define USER_OPTS_RESET 8'h00

// device state field
`define DEV_MODE_MSB 1
`define DEV_MODE_POWER_DOWN 2'h3

// user options field
`define OPT_ADDR_HOLD_BIT 0

// header framing: bit 15 is read/write, 14:0 the address
`define HDR_BITS 5'h10
`define HDR_LAST 5'h0f
`define HDR_RW_BIT 15
`define RW_READ 1'h1
`define BYTE_LAST 5'h07
`define BIT_CNT_ZERO 5'h00

// soft reset quiet window
`define SOFT_RESET_NS 750
`define CLK_PERIOD_NS 20
`define SOFT_RESET_CYCLES ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/spi_cfg_pkg.sv
// types shared by the serial-port configuration register bank
// assumes nothing beyond the defines header
package spi_cfg_pkg;

  // decoded frame header
  typedef struct packed {
    logic rw;
    logic [14:0] addr;
  } frame_header_t;

  // serial pins seen by the device
  typedef struct packed {
    logic sclk;
    logic scs_n;
    logic sdi;
  } serial_pins_t;

  // shifter phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_HEADER = 3'b010,
    PH_DATA = 3'b100
  } shift_phase_t;

endpackage

// ===== core/serial_frame_shifter.sv
// serial frame shifter: header capture, byte receive and transmit
// assumes serial pins synchronous to core_clk_i and sclk well below core_clk_i / 4
`timescale 1ns/100ps
`include "spi_cfg_defines.svh"

module serial_frame_shifter
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input spi_cfg_pkg::serial_pins_t pins_i,
  input wire logic [7:0] tx_byte_i,
  output spi_cfg_pkg::frame_header_t header_o,
  output logic header_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic dout_o,
  output logic dout_oe_o
);

  spi_cfg_pkg::shift_phase_t phase;
  logic sclk_last;
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  logic [7:0] shift_out;

  // edge detection on the serial clock while selected
  wire active = !pins_i.scs_n && !hold_i;
  wire rise = active && pins_i.sclk && !sclk_last;
  wire fall = active && !pins_i.sclk && sclk_last;
  wire [15:0] next_shift_in = {shift_in[14:0], pins_i.sdi};
  wire in_data = (phase == spi_cfg_pkg::PH_DATA);
  wire hdr_done = rise && !in_data && (bit_cnt == `HDR_LAST);
  wire byte_done = rise && in_data && (bit_cnt == `BYTE_LAST);
  wire [4:0] next_bit_cnt = (hdr_done || byte_done) ? `BIT_CNT_ZERO :
                            rise ? bit_cnt + 5'h01 : bit_cnt;

  // bit counting and phase tracking
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase <= spi_cfg_pkg::PH_IDLE;
      bit_cnt <= `BIT_CNT_ZERO;
      sclk_last <= 1'b0;
      shift_in <= 16'h0000;
    end
    else
    begin
      sclk_last <= pins_i.sclk;
      if (!active)
      begin
        phase <= spi_cfg_pkg::PH_IDLE;
        bit_cnt <= `BIT_CNT_ZERO;
      end
      else
      begin
        case (phase)
          spi_cfg_pkg::PH_IDLE,
          spi_cfg_pkg::PH_HEADER:
            phase <= hdr_done ? spi_cfg_pkg::PH_DATA : spi_cfg_pkg::PH_HEADER;
          spi_cfg_pkg::PH_DATA:
            phase <= spi_cfg_pkg::PH_DATA;
          default:
            phase <= spi_cfg_pkg::PH_IDLE;
        endcase
        bit_cnt <= next_bit_cnt;
        if (rise)
          shift_in <= next_shift_in;
      end
    end
  end

  // header and received byte strobes
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      header_o <= '0;
      header_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end
    else
    begin
      header_valid_o <= hdr_done;
      rx_valid_o <= byte_done;
      if (hdr_done)
        header_o <= next_shift_in;
      if (byte_done)
        rx_byte_o <= next_shift_in[7:0];
    end
  end

  // read data leaves msb first, changing on the falling edge
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_out <= 8'h00;
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
    end
    else
    begin
      dout_oe_o <= active;
      if (!active)
        dout_o <= 1'b0;
      else if (fall && in_data && bit_cnt == `BIT_CNT_ZERO)
      begin
        dout_o <= tx_byte_i[7];
        shift_out <= {tx_byte_i[6:0], 1'b0};
      end
      else if (fall && in_data)
      begin
        dout_o <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

endmodule

// ===== core/serial_port_config_registers.sv
// serial-port configuration register bank with soft reset and streaming
// assumes a host that keeps the serial pins synchronous to core_clk_i
`timescale 1ns/100ps
`include "spi_cfg_defines.svh"

module serial_port_config_registers
#(
  parameter logic [15:0] MAKER_CODE = 16'h5a3c, // arbitrary value
  parameter int SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic scs_n_i,
  input wire logic sdi_i,
  output logic serial_data_output_o,
  output logic serial_data_output_oe_o,
  output logic chip_soft_reset_o,
  output logic power_down_o
);

  spi_cfg_pkg::frame_header_t header;
  spi_cfg_pkg::serial_pins_t pins;
  logic header_valid;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] interface_configuration;
  logic [7:0] device_operating_state;
  logic [7:0] user_streaming_options;
  logic [14:0] cur_addr;
  logic cur_rw;
  logic [5:0] soft_cnt;

  // register read decode; bit 7 of config always reads back 0
  function automatic logic [7:0] read_reg(input logic [14:0] addr, input logic [7:0] cfg,
                                          input logic [7:0] dev, input logic [7:0] usr);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      `OFS_IFACE_CFG: val = cfg | `CFG_FIXED_ONES;
      `OFS_DEV_STATE: val = dev;
      `OFS_MAKER_LO: val = MAKER_CODE[7:0];
      `OFS_MAKER_HI: val = MAKER_CODE[15:8];
      `OFS_USER_OPTS: val = usr;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // streaming address step
  function automatic logic [14:0] step_addr(input logic [14:0] addr, input logic hold,
                                            input logic up);
    logic [14:0] res;
    res = addr;
    if (hold)
      res = addr;
    else if (up)
      res = addr + 15'h0001;
    else
      res = addr - 15'h0001;
    return res;
  endfunction

  assign pins = '{sclk: sclk_i, scs_n: scs_n_i, sdi: sdi_i};

  // write decode and soft reset request
  wire soft_active = (soft_cnt != 6'h00);
  wire wr_en = rx_valid && (cur_rw != `RW_READ);
  wire wr_cfg = wr_en && (cur_addr == `OFS_IFACE_CFG);
  wire wr_dev = wr_en && (cur_addr == `OFS_DEV_STATE);
  wire wr_usr = wr_en && (cur_addr == `OFS_USER_OPTS);
  wire soft_req = wr_cfg && rx_byte[`CFG_SOFT_RESET_BIT];
  wire soft_clear = soft_req || soft_active;
  wire [5:0] next_soft_cnt = soft_req ? 6'(SOFT_RESET_CYCLES) :
                             soft_active ? soft_cnt - 6'h01 : 6'h00;
  wire [7:0] next_cfg = (rx_byte & `CFG_WRITE_MASK) | `CFG_FIXED_ONES;
  wire [7:0] tx_byte = read_reg(cur_addr, interface_configuration,
                                device_operating_state, user_streaming_options);
  wire [14:0] next_addr = step_addr(cur_addr, user_streaming_options[`OPT_ADDR_HOLD_BIT],
                                    interface_configuration[`CFG_ASCEND_BIT]);

  // frame engine; held idle through the soft reset window
  serial_frame_shifter u_shifter
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .hold_i(soft_clear),
    .pins_i(pins),
    .tx_byte_i(tx_byte),
    .header_o(header),
    .header_valid_o(header_valid),
    .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid),
    .dout_o(serial_data_output_o),
    .dout_oe_o(serial_data_output_oe_o)
  );

  // soft reset window counter
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      soft_cnt <= 6'h00;
    else
      soft_cnt <= next_soft_cnt;
  end

  // configuration registers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      interface_configuration <= `IFACE_CFG_RESET;
      device_operating_state <= `DEV_STATE_RESET;
      user_streaming_options <= `USER_OPTS_RESET;
    end
    else if (soft_clear)
    begin
      interface_configuration <= `IFACE_CFG_RESET;
      device_operating_state <= `DEV_STATE_RESET;
      user_streaming_options <= `USER_OPTS_RESET;
    end
    else
    begin
      if (wr_cfg)
        interface_configuration <= next_cfg;
      if (wr_dev)
        device_operating_state <= rx_byte;
      if (wr_usr)
        user_streaming_options <= rx_byte;
    end
  end

  // current address: loaded from the header, stepped after each byte
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cur_addr <= 15'h0000;
      cur_rw <= 1'b0;
    end
    else if (header_valid)
    begin
      cur_addr <= header.addr;
      cur_rw <= header.rw;
    end
    else if (rx_valid)
      cur_addr <= next_addr;
  end

  // device-level outputs
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chip_soft_reset_o <= 1'b0;
      power_down_o <= 1'b0;
    end
    else
    begin
      chip_soft_reset_o <= (next_soft_cnt != 6'h00);
      power_down_o <= (device_operating_state[`DEV_MODE_MSB:0] == `DEV_MODE_POWER_DOWN);
    end
  end

endmodule

// ===== verification/serial_port_config_registers_chk.sv
// checker for the serial configuration register bank, bound to its ports
// assumes one clock domain and the active-high asynchronous reset rst_i
`timescale 1ns/100ps

module serial_port_config_registers_chk
#(
  parameter logic [15:0] MAKER_CODE = 16'h5a3c, // arbitrary value
  parameter int SOFT_RESET_CYCLES = 38
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic scs_n_i,
  input wire logic sdi_i,
  input wire logic serial_data_output_o,
  input wire logic serial_data_output_oe_o,
  input wire logic chip_soft_reset_o,
  input wire logic power_down_o
);
  logic [7:0] hi_cnt;

  default clocking dflt @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // counts the cycles of the soft reset window
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= chip_soft_reset_o ? hi_cnt + 8'h01 : 8'h00;
  end

  // port idle with no reset pending, and port busy
  sequence quiet3;
    (scs_n_i && !chip_soft_reset_o)[*3];
  endsequence
  sequence busy2;
    (!scs_n_i && !chip_soft_reset_o)[*2];
  endsequence

  oe_on_a: assert property (busy2 |-> serial_data_output_oe_o)
    else $error("serial output not driven while selected");
  oe_off_a: assert property (scs_n_i ##1 scs_n_i |-> !serial_data_output_oe_o)
    else $error("serial output driven while deselected");
  out_idle_a: assert property (scs_n_i ##1 scs_n_i |-> !serial_data_output_o)
    else $error("serial output not low while deselected");
  out_fall_a: assert property (!scs_n_i && $past(scs_n_i) == 1'b0 &&
    !chip_soft_reset_o && $changed(serial_data_output_o) |-> $past(sclk_i) == 1'b0)
    else $error("serial output moved without a serial clock fall");
  sr_len_a: assert property ($fell(chip_soft_reset_o) |-> int'(hi_cnt) == SOFT_RESET_CYCLES)
    else $error("soft reset window has wrong length");
  sr_max_a: assert property (chip_soft_reset_o |-> int'(hi_cnt) < SOFT_RESET_CYCLES)
    else $error("soft reset window too long");
  sr_pd_a: assert property ($rose(chip_soft_reset_o) |-> ##[0:2] !power_down_o)
    else $error("power down survived soft reset");
  sr_cause_a: assert property ($rose(chip_soft_reset_o) |-> $past(scs_n_i) == 1'b0)
    else $error("soft reset without a frame");
  pd_hold_a: assert property (quiet3 |=> $stable(power_down_o))
    else $error("power down moved with the port idle");
endmodule

bind serial_port_config_registers serial_port_config_registers_chk
  #(.MAKER_CODE(MAKER_CODE), .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .scs_n_i(scs_n_i), .sdi_i(sdi_i),
  .serial_data_output_o(serial_data_output_o), .serial_data_output_oe_o(serial_data_output_oe_o),
  .chip_soft_reset_o(chip_soft_reset_o), .power_down_o(power_down_o));

// ===== verification/serial_host.sv
// host model driving the serial programming port
// assumes pins change on the falling core clock edge
`timescale 1ns/100ps

module serial_host
(
  input wire logic core_clk_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic scs_n_o,
  output logic sdi_o
);
  // idle: deselected, clock parked low
  initial
  begin
    sclk_o = 1'b0;
    scs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // one frame: header then n bytes msb first; read bits taken before each rise
  task automatic frame(input logic rw, input logic [14:0] addr, input int n,
    input logic [31:0] wd, output logic [31:0] rd);
    logic [47:0] sh;
    sh = {rw, addr, wd << (8 * (4 - n))};
    rd = 32'h0;
    @(negedge core_clk_i);
    scs_n_o = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++)
    begin
      sdi_o = sh[47 - i];
      sclk_o = 1'b0;
      repeat (3) @(negedge core_clk_i);
      if (i >= 16)
        rd = {rd[30:0], dout_i};
      sclk_o = 1'b1;
      repeat (2) @(negedge core_clk_i);
    end
    sclk_o = 1'b0;
    repeat (4) @(negedge core_clk_i);
    scs_n_o = 1'b1;
    sdi_o = ~sdi_o; // released line shows no stale value
    repeat (2) @(negedge core_clk_i);
  endtask

  // stay off the port while the device resets
  task automatic quiet(input int cycles);
    repeat (cycles) @(negedge core_clk_i);
  endtask
endmodule

// ===== verification/serial_port_config_registers_test.sv
// self-checking bench for the serial configuration register bank
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/100ps

module serial_port_config_registers_test;
  localparam int SRC = 8;
  localparam logic [15:0] CODE = 16'h5a3c; // arbitrary value
  localparam int QUIET = 38; // 750 ns in 20 ns cycles, rounded up
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, scs_n, sdi, dout, dout_oe, soft_rst, pd;
  logic sr_seen = 1'b0;
  logic [31:0] rd;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  serial_port_config_registers #(.MAKER_CODE(CODE), .SOFT_RESET_CYCLES(SRC)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk), .scs_n_i(scs_n), .sdi_i(sdi),
    .serial_data_output_o(dout), .serial_data_output_oe_o(dout_oe),
    .chip_soft_reset_o(soft_rst), .power_down_o(pd));
  serial_host host (.core_clk_i(core_clk_i), .dout_i(dout), .sclk_o(sclk), .scs_n_o(scs_n),
    .sdi_o(sdi));

  // clock, hang limit and soft reset watch, sampled away from the launching edge
  always #10 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i)
  begin
    cycles++;
    sr_seen = sr_seen | (soft_rst === 1'b1);
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.frame(1'b0, a, 1, {24'h0, d}, rd);
  endtask

  task automatic rd1(input logic [14:0] a, input logic [7:0] exp);
    host.frame(1'b1, a, 1, 32'h0, rd);
    chk8(rd[7:0], exp);
  endtask

  // reset values and an unmapped place
  task automatic t_reset();
    rd1(15'h0000, 8'h30);
    rd1(15'h0002, 8'h00);
    rd1(15'h0010, 8'h00);
    rd1(15'h0004, 8'h00);
  endtask

  // read-only fields and ascending maker code stream
  task automatic t_readonly();
    wr(15'h000c, 8'hff);
    wr(15'h0000, 8'h20);
    rd1(15'h0000, 8'h30);
    host.frame(1'b1, 15'h000c, 2, 32'h0, rd);
    chk8(rd[15:8], CODE[7:0]);
    chk8(rd[7:0], CODE[15:8]);
  endtask

  // descending stream, then address hold
  task automatic t_stream();
    wr(15'h0000, 8'h00);
    host.frame(1'b1, 15'h000d, 2, 32'h0, rd);
    chk8(rd[15:8], CODE[15:8]);
    chk8(rd[7:0], CODE[7:0]);
    wr(15'h0010, 8'h01);
    host.frame(1'b1, 15'h000c, 3, 32'h0, rd);
    chk8(rd[23:16], CODE[7:0]);
    chk8(rd[15:8], CODE[7:0]);
    chk8(rd[7:0], CODE[7:0]);
    wr(15'h0010, 8'h00);
    wr(15'h0000, 8'h30);
  endtask

  // every device state code
  task automatic t_mode();
    for (int m = 0; m < 4; m++)
    begin
      wr(15'h0002, 8'(m));
      chk8({7'h0, pd}, {7'h0, m == 3});
      rd1(15'h0002, 8'(m));
    end
  endtask

  // soft reset from power down, descending and address hold set beforehand
  task automatic t_soft();
    wr(15'h0000, 8'h00);
    wr(15'h0010, 8'h01);
    wr(15'h0000, 8'h80);
    host.quiet(QUIET);
    chk8({7'h0, sr_seen}, 8'h01);
    chk8({7'h0, pd}, 8'h00);
    rd1(15'h0000, 8'h30);
    rd1(15'h0002, 8'h00);
    rd1(15'h0010, 8'h00);
  endtask

  initial
  begin
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_readonly();
    t_stream();
    t_mode();
    wr(15'h0002, 8'h03);
    t_soft();
    close_out();
  end
endmodule
